// ---- rtl/erase_addr_pkg.sv ----
// Constants for the flash page erase addressing block
package erase_addr_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses on APB)
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_PAGE_SELECT = 8'h00;
	localparam logic [7:0] OFF_ERASE_CMD   = 8'h04;
	localparam logic [7:0] OFF_STATUS      = 8'h08;
	localparam logic [7:0] OFF_CONFIG      = 8'h0C;
	localparam logic [7:0] OFF_RAM_ADDR    = 8'h10;
	localparam logic [7:0] OFF_RAM_DATA    = 8'h14;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int CMD_PAGE_BIT      = 0;
	localparam int CMD_MASS_BIT      = 1;
	localparam int STS_BUSY_BIT      = 0;
	localparam int STS_REFUSED_BIT   = 1;
	localparam int STS_LOCK_BIT      = 2;
	localparam int STS_PAGE_LSB      = 8;
	localparam int CFG_LOCK_BIT      = 0;
	localparam logic [7:0] PAGE_SELECT_RESET = 8'h00;
	localparam logic       LOCK_RESET        = 1'b0;

	// ------------------------------------------------------------
	// Flash geometry
	// ------------------------------------------------------------
	localparam int PAGE_BYTES     = 512;
	localparam int PAGE_COUNT     = 128;
	localparam int PAGE_BITS      = 7;
	localparam int PAGE_SHIFT     = 9;
	localparam int FLASH_ADDR_W   = 16;
	localparam logic [6:0] PROTECTED_PAGE = 7'h00;

	// ------------------------------------------------------------
	// User data RAM geometry
	// ------------------------------------------------------------
	localparam int RAM_AW    = 8;
	localparam int RAM_DW    = 8;
	localparam int RAM_DEPTH = 256;
	localparam logic [7:0] RAM_LAST = 8'hFF;

	// ------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PAGE,
		ST_MASS
	} seq_state_t;

endpackage : erase_addr_pkg

// ---- rtl/user_ram.sv ----
// Small synchronous user data RAM with registered read data
`timescale 1ns/10ps
module user_ram (
	input  wire logic                             clk_in,
	input  wire logic                             resetn_in,
	input  wire logic                             we_in,
	input  wire logic [erase_addr_pkg::RAM_AW-1:0] addr_in,
	input  wire logic [erase_addr_pkg::RAM_DW-1:0] wdata_in,
	output logic      [erase_addr_pkg::RAM_DW-1:0] rdata_out
);
	import erase_addr_pkg::*;

	logic [RAM_DW-1:0] mem [RAM_DEPTH];

	// Storage write port
	always_ff @(posedge clk_in) begin
		if (we_in) begin
			mem[addr_in] <= wdata_in;
		end
	end

	// Read data register
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rdata_out <= 8'h00;
		end else begin
			rdata_out <= mem[addr_in];
		end
	end

endmodule : user_ram

// ---- rtl/flash_page_erase_addressing.sv ----
// Flash erase addressing, page zero protection and RAM clearing
`timescale 1ns/10ps
// Behaviour
// [RQ1] A page erase clears exactly one aligned 512-byte flash region.
// [RQ2] 128 erasable pages exist; the selector reaches every one.
// [RQ3] Select bits seven to one drive flash address bits fifteen to nine.
// [RQ4] Select bit zero is ignored when choosing the page.
// [RQ5] Page erase of page zero is refused from core or debug port.
// [RQ6] Whole-array erase clears user data RAM, lock bit notwithstanding.
// [RQ7] Caller loads the select before erasing and holds it meanwhile.
module flash_page_erase_addressing (
	input  wire logic        SYS_CLK_IN,
	input  wire logic        RESETN_IN,
	input  wire logic        PSEL_IN,
	input  wire logic        PENABLE_IN,
	input  wire logic        PWRITE_IN,
	input  wire logic [7:0]  PADDR_IN,
	input  wire logic [31:0] PWDATA_IN,
	output logic      [31:0] PRDATA_OUT,
	output logic             PREADY_OUT,
	output logic             PSLVERR_OUT,
	input  wire logic        DBG_PAGE_ERASE_IN,
	input  wire logic        DBG_MASS_ERASE_IN,
	input  wire logic        FLASH_DONE_IN,
	output logic             FLASH_PAGE_ERASE_OUT,
	output logic             FLASH_MASS_ERASE_OUT,
	output logic [erase_addr_pkg::FLASH_ADDR_W-1:0] FLASH_ERASE_ADDR_OUT,
	output logic             BUSY_OUT
);
	import erase_addr_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	seq_state_t          state_q,        state_d;
	logic [7:0]          sel_q,          sel_d;
	logic                lock_q,         lock_d;
	logic                refused_q,      refused_d;
	logic [RAM_AW-1:0]   ram_addr_q,     ram_addr_d;
	logic [RAM_AW-1:0]   clr_idx_q,      clr_idx_d;
	logic                clr_done_q,     clr_done_d;
	logic                flash_done_q,   flash_done_d;
	logic                pready_q,       pready_d;
	logic                pslverr_q,      pslverr_d;
	logic [31:0]         prdata_q,       prdata_d;
	logic                page_pulse_q,   page_pulse_d;
	logic                mass_pulse_q,   mass_pulse_d;
	logic [FLASH_ADDR_W-1:0] erase_addr_q, erase_addr_d;
	logic                busy_q,         busy_d;

	logic                acc;
	logic                wr;
	logic                req_page;
	logic                req_mass;
	logic [PAGE_BITS-1:0] page_num;
	logic                ram_we;
	logic [RAM_AW-1:0]   ram_addr;
	logic [RAM_DW-1:0]   ram_wdata;
	logic [RAM_DW-1:0]   ram_rdata;

	// ------------------------------------------------------------
	// User data RAM
	// ------------------------------------------------------------
	user_ram u_ram (
		.clk_in    (SYS_CLK_IN),
		.resetn_in (RESETN_IN),
		.we_in     (ram_we),
		.addr_in   (ram_addr),
		.wdata_in  (ram_wdata),
		.rdata_out (ram_rdata)
	);

	// Access strobe, one wait state per transfer
	assign acc = PSEL_IN & PENABLE_IN & ~pready_q;
	assign wr  = acc & PWRITE_IN;

	// Page number from the upper seven select bits only
	assign page_num = sel_q[7:1];          // see [RQ3] see [RQ4]

	// Erase requests from core register or debug emulator port
	assign req_page = (wr && PADDR_IN == OFF_ERASE_CMD
		&& PWDATA_IN[CMD_PAGE_BIT]) || DBG_PAGE_ERASE_IN;
	assign req_mass = (wr && PADDR_IN == OFF_ERASE_CMD
		&& PWDATA_IN[CMD_MASS_BIT]) || DBG_MASS_ERASE_IN;

	// RAM port: clearing sweep owns it during a whole-array erase
	always_comb begin
		if (state_q == ST_MASS && !clr_done_q) begin
			ram_we    = 1'b1;                // see [RQ6]
			ram_addr  = clr_idx_q;
			ram_wdata = 8'h00;
		end else begin
			ram_we    = wr && PADDR_IN == OFF_RAM_DATA
				&& state_q != ST_MASS;
			ram_addr  = ram_addr_q;
			ram_wdata = PWDATA_IN[RAM_DW-1:0];
		end
	end

	// ------------------------------------------------------------
	// Next state: bus slave, registers and erase sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_d      = state_q;
		sel_d        = sel_q;
		lock_d       = lock_q;
		refused_d    = refused_q;
		ram_addr_d   = ram_addr_q;
		clr_idx_d    = clr_idx_q;
		clr_done_d   = clr_done_q;
		flash_done_d = flash_done_q;
		pready_d     = acc;
		pslverr_d    = 1'b0;
		prdata_d     = prdata_q;
		page_pulse_d = 1'b0;
		mass_pulse_d = 1'b0;
		erase_addr_d = erase_addr_q;

		// Register reads and writes
		if (acc) begin
			prdata_d = 32'h0000_0000;
			case (PADDR_IN)
				OFF_PAGE_SELECT: begin
					prdata_d[7:0] = sel_q;
					if (PWRITE_IN) begin
						if (state_q == ST_IDLE) begin
							sel_d = PWDATA_IN[7:0];
						end else begin
							pslverr_d = 1'b1;  // see [RQ7]
						end
					end
				end
				OFF_ERASE_CMD: begin
					if (PWRITE_IN && state_q != ST_IDLE) begin
						pslverr_d = 1'b1;
					end
				end
				OFF_STATUS: begin
					prdata_d[STS_BUSY_BIT]    = state_q != ST_IDLE;
					prdata_d[STS_REFUSED_BIT] = refused_q;
					prdata_d[STS_LOCK_BIT]    = lock_q;
					prdata_d[STS_PAGE_LSB +: PAGE_BITS] = page_num;
					if (PWRITE_IN && PWDATA_IN[STS_REFUSED_BIT]) begin
						refused_d = 1'b0;
					end
				end
				OFF_CONFIG: begin
					prdata_d[CFG_LOCK_BIT] = lock_q;
					if (PWRITE_IN) begin
						lock_d = PWDATA_IN[CFG_LOCK_BIT];
					end
				end
				OFF_RAM_ADDR: begin
					prdata_d[RAM_AW-1:0] = ram_addr_q;
					if (PWRITE_IN) begin
						ram_addr_d = PWDATA_IN[RAM_AW-1:0];
					end
				end
				OFF_RAM_DATA: begin
					prdata_d[RAM_DW-1:0] = ram_rdata;
					if (state_q == ST_MASS) begin
						pslverr_d = 1'b1;
					end
				end
				default: begin
					pslverr_d = 1'b1;
				end
			endcase
		end

		// Erase sequencer
		case (state_q)
			ST_IDLE: begin
				if (req_mass) begin
					state_d      = ST_MASS;
					mass_pulse_d = 1'b1;
					erase_addr_d = 16'h0000;
					clr_idx_d    = 8'h00;
					clr_done_d   = 1'b0;
					flash_done_d = 1'b0;
				end else if (req_page) begin
					if (page_num == PROTECTED_PAGE) begin
						refused_d = 1'b1;          // see [RQ5]
					end else begin
						state_d      = ST_PAGE;
						page_pulse_d = 1'b1;
						// Aligned 512-byte page base
						erase_addr_d = {page_num,
							{PAGE_SHIFT{1'b0}}};    // see [RQ1] see [RQ2]
					end
				end
			end
			ST_PAGE: begin
				if (FLASH_DONE_IN) begin
					state_d = ST_IDLE;
				end
			end
			ST_MASS: begin
				if (!clr_done_q) begin
					clr_idx_d = clr_idx_q + 8'h01;
					if (clr_idx_q == RAM_LAST) begin
						clr_done_d = 1'b1;       // see [RQ6]
					end
				end
				if (FLASH_DONE_IN) begin
					flash_done_d = 1'b1;
				end
				if ((clr_done_q || (!clr_done_q && clr_idx_q == RAM_LAST))
					&& (flash_done_q || FLASH_DONE_IN)) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase

		// Refusal flag: a new refusal beats a clear in the same cycle
		if (state_q == ST_IDLE && !req_mass && req_page
			&& page_num == PROTECTED_PAGE) begin
			refused_d = 1'b1;                    // see [RQ5]
		end

		// Busy follows the next state so the output comes from a flop
		busy_d = state_d != ST_IDLE;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			state_q      <= ST_IDLE;
			sel_q        <= PAGE_SELECT_RESET;
			lock_q       <= LOCK_RESET;
			refused_q    <= 1'b0;
			ram_addr_q   <= 8'h00;
			clr_idx_q    <= 8'h00;
			clr_done_q   <= 1'b1;
			flash_done_q <= 1'b0;
			pready_q     <= 1'b0;
			pslverr_q    <= 1'b0;
			prdata_q     <= 32'h0000_0000;
			page_pulse_q <= 1'b0;
			mass_pulse_q <= 1'b0;
			erase_addr_q <= 16'h0000;
			busy_q       <= 1'b0;
		end else begin
			state_q      <= state_d;
			sel_q        <= sel_d;
			lock_q       <= lock_d;
			refused_q    <= refused_d;
			ram_addr_q   <= ram_addr_d;
			clr_idx_q    <= clr_idx_d;
			clr_done_q   <= clr_done_d;
			flash_done_q <= flash_done_d;
			pready_q     <= pready_d;
			pslverr_q    <= pslverr_d;
			prdata_q     <= prdata_d;
			page_pulse_q <= page_pulse_d;
			mass_pulse_q <= mass_pulse_d;
			erase_addr_q <= erase_addr_d;
			busy_q       <= busy_d;
		end
	end

	// Outputs straight from flops
	assign PRDATA_OUT           = prdata_q;
	assign PREADY_OUT           = pready_q;
	assign PSLVERR_OUT          = pslverr_q;
	assign FLASH_PAGE_ERASE_OUT = page_pulse_q;
	assign FLASH_MASS_ERASE_OUT = mass_pulse_q;
	assign FLASH_ERASE_ADDR_OUT = erase_addr_q;
	assign BUSY_OUT             = busy_q;

endmodule : flash_page_erase_addressing

// ---- tb/erase_addr_asserts.sv ----
// Concurrent checks on the erase addressing block ports
`timescale 1ns/10ps
module erase_addr_checker
	import erase_addr_pkg::*;
(
	input wire logic        SYS_CLK_IN,
	input wire logic        RESETN_IN,
	input wire logic        PSEL_IN,
	input wire logic        PENABLE_IN,
	input wire logic        PWRITE_IN,
	input wire logic [7:0]  PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	input wire logic        PREADY_OUT,
	input wire logic        PSLVERR_OUT,
	input wire logic        FLASH_PAGE_ERASE_OUT,
	input wire logic        FLASH_MASS_ERASE_OUT,
	input wire logic [15:0] FLASH_ERASE_ADDR_OUT,
	input wire logic        BUSY_OUT
);
	logic [7:0] sel_q;
	logic [7:0] sel_d;
	logic       wr_sel;
	// Shadow of accepted page select writes
	assign wr_sel = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;
	always_comb begin
		sel_d = sel_q;
		if (wr_sel && !PSLVERR_OUT && PADDR_IN == OFF_PAGE_SELECT) begin
			sel_d = PWDATA_IN[7:0];
		end
	end
	always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) sel_q <= PAGE_SELECT_RESET;
		else sel_q <= sel_d;
	end
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (!RESETN_IN);
	sequence s_wait;
		PSEL_IN && PENABLE_IN && !PREADY_OUT;
	endsequence
	sequence s_launch;
		FLASH_PAGE_ERASE_OUT || FLASH_MASS_ERASE_OUT;
	endsequence
	a_apb_one_wait: assert property (s_wait |=> PREADY_OUT)
		else $error("answer not one cycle after access");
	a_err_with_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
		else $error("error without ready");
	a_page_aligned: assert property (
		FLASH_PAGE_ERASE_OUT |-> FLASH_ERASE_ADDR_OUT[8:0] == 9'h000)
		else $error("page address not aligned");
	a_page_mapping: assert property (
		FLASH_PAGE_ERASE_OUT |-> FLASH_ERASE_ADDR_OUT[15:9] == sel_q[7:1])
		else $error("page address not from select bits");
	a_page_zero_kept: assert property (
		FLASH_PAGE_ERASE_OUT |-> FLASH_ERASE_ADDR_OUT[15:9] != 7'h00)
		else $error("page zero page erase launched");
	a_mass_sweep: assert property (
		FLASH_MASS_ERASE_OUT |-> BUSY_OUT [*8])
		else $error("busy dropped during whole erase");
	a_mass_addr: assert property (
		FLASH_MASS_ERASE_OUT |-> FLASH_ERASE_ADDR_OUT == 16'h0000
		##1 !FLASH_MASS_ERASE_OUT)
		else $error("whole erase address or pulse wrong");
	a_launch_busy: assert property (s_launch |-> BUSY_OUT)
		else $error("launch without busy");
endmodule : erase_addr_checker

bind flash_page_erase_addressing erase_addr_checker chk_u (
	.SYS_CLK_IN(SYS_CLK_IN), .RESETN_IN(RESETN_IN), .PSEL_IN(PSEL_IN),
	.PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
	.PWDATA_IN(PWDATA_IN), .PREADY_OUT(PREADY_OUT),
	.PSLVERR_OUT(PSLVERR_OUT), .FLASH_PAGE_ERASE_OUT(FLASH_PAGE_ERASE_OUT),
	.FLASH_MASS_ERASE_OUT(FLASH_MASS_ERASE_OUT),
	.FLASH_ERASE_ADDR_OUT(FLASH_ERASE_ADDR_OUT), .BUSY_OUT(BUSY_OUT));

// ---- tb/flash_array_model.sv ----
// Flash array stand-in answering erase starts with a done pulse
`timescale 1ns/10ps
module flash_array_model #(
	parameter int DELAY = 4
) (
	input  wire logic clk_in,
	input  wire logic page_in,
	input  wire logic mass_in,
	output logic      done_out
);
	int cnt = 0;
	// Count down after each start, pulse done at the end
	always @(posedge clk_in) begin
		done_out <= 1'b0;
		if (page_in || mass_in) cnt <= DELAY;
		else if (cnt > 1) cnt <= cnt - 1;
		else if (cnt == 1) begin
			cnt <= 0;
			done_out <= 1'b1;
		end
	end
endmodule : flash_array_model

// ---- tb/testbench.sv ----
// Self-checking bench for the flash erase addressing block
`timescale 1ns/10ps
module testbench;
	import erase_addr_pkg::*;
	logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, dpg = 0, dms = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwd = 0, prd, rd;
	logic rdy, serr, err, done, pgo, mgo, busy;
	logic [15:0] eaddr, last_addr;
	int mismatches = 0, compares = 0, pcnt = 0, mcnt = 0;
	logic [7:0] tab [4] = '{8'h03, 8'h02, 8'hFF, 8'h80};
	always #25 clk = ~clk;
	flash_page_erase_addressing dut_u (.SYS_CLK_IN(clk), .RESETN_IN(rstn),
		.PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
		.PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(rdy),
		.PSLVERR_OUT(serr), .DBG_PAGE_ERASE_IN(dpg), .DBG_MASS_ERASE_IN(dms),
		.FLASH_DONE_IN(done), .FLASH_PAGE_ERASE_OUT(pgo),
		.FLASH_MASS_ERASE_OUT(mgo), .FLASH_ERASE_ADDR_OUT(eaddr),
		.BUSY_OUT(busy));
	// Long erase so a select write can meet a busy block
	flash_array_model #(.DELAY(20)) fl_u (.clk_in(clk), .page_in(pgo),
		.mass_in(mgo), .done_out(done));
	// Count launches and keep the last page address
	always @(posedge clk) begin
		if (pgo === 1'b1) begin
			pcnt++;
			last_addr <= eaddr;
		end
		if (mgo === 1'b1) mcnt++;
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	// One APB transfer, held until ready is seen
	task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		// Ready, data and error are taken at the completing edge
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'b1 && n < 50);
		if (n >= 50) chk(32'h0, 32'h1);
		rd = prd;
		err = serr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : xfer
	task pulse(input logic m);
		@(posedge clk);
		if (m) dms <= 1'b1;
		else dpg <= 1'b1;
		@(posedge clk);
		dms <= 1'b0;
		dpg <= 1'b0;
	endtask : pulse
	task wait_idle;
		int n;
		n = 0;
		repeat (2) @(negedge clk);
		while (busy !== 1'b0 && n < 1000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 1000) chk(32'h0, 32'h1);
	endtask : wait_idle
	task report_and_stop;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	// Tests need about 1000 cycles; allow ten times that
	initial begin
		#500000;
		mismatches++;
		report_and_stop();
	end
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		xfer(OFF_PAGE_SELECT, 1'b0, 32'h0);
		chk(rd, {24'h00_0000, PAGE_SELECT_RESET});
		xfer(8'h1C, 1'b0, 32'h0);
		chk(rd, 32'h0000_0000);
		chk({31'h0, err}, 32'h0000_0001);
		foreach (tab[i]) begin
			xfer(OFF_PAGE_SELECT, 1'b1, {24'h00_0000, tab[i]});
			xfer(OFF_ERASE_CMD, 1'b1, 32'h0000_0001);
			wait_idle();
			chk(pcnt, i + 1);
			chk(last_addr, {tab[i][7:1], 9'h000});
		end
		// Debug port page erase; select write refused while busy
		xfer(OFF_PAGE_SELECT, 1'b1, 32'h0000_0010);
		pulse(1'b0);
		xfer(OFF_PAGE_SELECT, 1'b1, 32'h0000_0020);
		chk({31'h0, err}, 32'h0000_0001);
		wait_idle();
		chk(pcnt, 5);
		chk(last_addr, 16'h1000);
		xfer(OFF_PAGE_SELECT, 1'b0, 32'h0);
		chk(rd, 32'h0000_0010);
		// Page zero refused from the register, then from the debug port
		xfer(OFF_PAGE_SELECT, 1'b1, 32'h0000_0001);
		xfer(OFF_ERASE_CMD, 1'b1, 32'h0000_0001);
		xfer(OFF_STATUS, 1'b0, 32'h0);
		chk({31'h0, rd[1]}, 32'h0000_0001);
		xfer(OFF_STATUS, 1'b1, 32'h0000_0002);
		xfer(OFF_STATUS, 1'b0, 32'h0);
		chk({31'h0, rd[1]}, 32'h0000_0000);
		pulse(1'b0);
		wait_idle();
		chk(pcnt, 5);
		xfer(OFF_STATUS, 1'b0, 32'h0);
		chk({31'h0, rd[1]}, 32'h0000_0001);
		xfer(OFF_RAM_ADDR, 1'b1, 32'h0000_0005);
		xfer(OFF_RAM_DATA, 1'b1, 32'h0000_00A5);
		xfer(OFF_RAM_DATA, 1'b0, 32'h0);
		xfer(OFF_RAM_DATA, 1'b0, 32'h0);
		chk(rd, 32'h0000_00A5);
		// Whole erase from the debug port with the lock bit set
		xfer(OFF_CONFIG, 1'b1, 32'h0000_0001);
		pulse(1'b1);
		wait_idle();
		chk(mcnt, 1);
		xfer(OFF_RAM_ADDR, 1'b1, 32'h0000_0005);
		xfer(OFF_RAM_DATA, 1'b0, 32'h0);
		xfer(OFF_RAM_DATA, 1'b0, 32'h0);
		chk(rd, 32'h0000_0000);
		// Whole erase from the command register with the lock bit clear
		xfer(OFF_RAM_DATA, 1'b1, 32'h0000_005A);
		xfer(OFF_RAM_DATA, 1'b0, 32'h0);
		xfer(OFF_RAM_DATA, 1'b0, 32'h0);
		chk(rd, 32'h0000_005A);
		xfer(OFF_CONFIG, 1'b1, 32'h0000_0000);
		xfer(OFF_ERASE_CMD, 1'b1, 32'h0000_0002);
		wait_idle();
		chk(mcnt, 2);
		xfer(OFF_RAM_DATA, 1'b0, 32'h0);
		xfer(OFF_RAM_DATA, 1'b0, 32'h0);
		chk(rd, 32'h0000_0000);
		report_and_stop();
	end
endmodule : testbench
